/* src/cie_unit.sv */
// cie_unit: interrupt entry/return sequencing with apb registers and register-file alu
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cie_unit import cie_pkg::*; #(
  parameter int NSRC = 8,
  parameter int PC_W = 17,
  parameter int NREG = 32,
  parameter logic [NSRC-1:0] LEVEL_MASK = '0,
  parameter logic [PC_W-1:0] BOOT_START = '0
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // sources
  input wire logic [NSRC-1:0] src_event_i,
  input wire logic [NSRC-1:0] src_level_i,
  output logic [NSRC-1:0] src_ack_o,
  // straps
  input wire logic boot_reset_fuse_i,
  input wire logic boot_lock_app_bit_i,
  input wire logic boot_lock_boot_bit_i,
  // pipeline
  input wire logic [PC_W-1:0] pc_i,
  input wire logic instr_done_i,
  input wire logic set_gie_instr_i,
  input wire logic clr_gie_instr_i,
  input wire logic return_from_handler_instr_i,
  input wire logic sleep_i,
  input wire logic wake_ready_i,
  output logic busy_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_load_addr_o,
  output logic [PC_W-1:0] reset_vector_o,
  output logic global_enable_o,
  // stack memory, one byte per access, read data one cycle later
  output logic stack_we_o,
  output logic stack_re_o,
  output logic [15:0] stack_addr_o,
  output logic [7:0] stack_wdata_o,
  input wire logic [7:0] stack_rdata_i,
  // register-file alu
  input wire logic alu_valid_i,
  input wire logic [1:0] alu_op_i,
  input wire logic [$clog2(NREG)-1:0] alu_rd_i,
  input wire logic [$clog2(NREG)-1:0] alu_rr_i,
  output logic [7:0] alu_result_o
);

  localparam int SW = $clog2(NSRC);

  function automatic logic [SW-1:0] first_set(input logic [NSRC-1:0] v);
    logic [SW-1:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = SW'(i);
      end
    end
    return r;
  endfunction : first_set

  function automatic logic [PC_W-1:0] vec_addr(input logic vsel, input logic [SW-1:0] idx);
    logic [PC_W-1:0] base;
    base = vsel ? BOOT_START : '0;
    return base + PC_W'((32'(idx) + 32'd1) * 32'(CIE_VEC_WORDS));
  endfunction : vec_addr

  cie_state_t st;
  logic [3:0] cnt;
  logic [3:0] entry_last;
  logic gie;
  logic vsel;
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] enable;
  logic [15:0] sp;
  logic [PC_W-1:0] saved_pc;
  logic [SW-1:0] sel;
  logic [7:0] regs [NREG];

  logic [NSRC-1:0] pending;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] w1c;
  logic [NSRC-1:0] sel_onehot;
  logic in_boot;
  logic lock_block;
  logic at_boundary;
  logic take;
  logic ret_start;
  logic entry_end;
  logic ret_end;
  logic [23:0] pc_bytes;
  logic apb_wr;
  logic mapped;

  // level sources bypass the flag store entirely
  assign pending = (flags & ~LEVEL_MASK) | (src_level_i & LEVEL_MASK);
  assign req = pending & enable;
  assign in_boot = pc_i >= BOOT_START;
  // vectors in the other section are fenced off from locked code
  assign lock_block = (boot_lock_app_bit_i & ~in_boot & vsel) |
                      (boot_lock_boot_bit_i & in_boot & ~vsel);
  // decisions only at instruction completion, or once a sleep start-up has run out
  assign at_boundary = instr_done_i | (sleep_i & wake_ready_i);
  // clear-enable in the same cycle already vetoes; set-enable acts only after next instruction
  assign take = (st == CIE_ST_IDLE) & at_boundary & gie & ~clr_gie_instr_i &
                ~set_gie_instr_i & ~return_from_handler_instr_i & ~lock_block &
                (|req);
  assign ret_start = (st == CIE_ST_IDLE) & instr_done_i & return_from_handler_instr_i;
  assign entry_end = (st == CIE_ST_ENTRY) & (cnt == entry_last);
  assign ret_end = (st == CIE_ST_RETURN) & (cnt == 4'(CIE_RETURN_CYCLES - 1));
  assign sel_onehot = NSRC'(1) << sel;
  assign pc_bytes = 24'(saved_pc);
  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign w1c = (apb_wr & (paddr_i == CIE_OFF_FLAG)) ? pwdata_i[NSRC-1:0] : '0;
  assign mapped = (paddr_i == CIE_OFF_CTRL) | (paddr_i == CIE_OFF_FLAG) |
                  (paddr_i == CIE_OFF_ENABLE) | (paddr_i == CIE_OFF_SP) |
                  (paddr_i == CIE_OFF_STATE);

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign busy_o = st != CIE_ST_IDLE;
  assign global_enable_o = gie;
  assign src_ack_o = take ? (NSRC'(1) << first_set(req)) : '0;
  assign pc_load_o = entry_end | ret_end;

  // sequencer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= CIE_ST_IDLE;
      cnt <= '0;
      entry_last <= '0;
      sel <= '0;
      saved_pc <= '0;
    end else begin
      case (st)
        CIE_ST_IDLE: begin
          cnt <= '0;
          if (take) begin
            st <= CIE_ST_ENTRY;
            sel <= first_set(req);
            saved_pc <= pc_i;
            entry_last <= sleep_i ?
              4'(CIE_ENTRY_CYCLES + CIE_WAKE_EXTRA_CYCLES - 1) :
              4'(CIE_ENTRY_CYCLES - 1);
          end else if (ret_start) begin
            st <= CIE_ST_RETURN;
          end
        end
        CIE_ST_ENTRY: begin
          cnt <= cnt + 4'd1;
          if (entry_end) begin
            st <= CIE_ST_IDLE;
          end
        end
        CIE_ST_RETURN: begin
          cnt <= cnt + 4'd1;
          if (cnt >= 4'd1 && cnt <= 4'(CIE_PC_BYTES)) begin
            saved_pc <= PC_W'({pc_bytes[15:0], stack_rdata_i});
          end
          if (ret_end) begin
            st <= CIE_ST_IDLE;
          end
        end
        default: begin
          st <= CIE_ST_IDLE;
        end
      endcase
    end
  end

  // only the program_counter goes on the stack; status_register is left to software
  always_comb begin
    stack_we_o = 1'b0;
    stack_re_o = 1'b0;
    stack_addr_o = sp;
    stack_wdata_o = 8'h00;
    pc_load_addr_o = saved_pc;
    if (st == CIE_ST_ENTRY && cnt < 4'(CIE_PC_BYTES)) begin
      stack_we_o = 1'b1;
      stack_addr_o = sp - 16'(cnt);
      stack_wdata_o = pc_bytes[8*cnt[1:0] +: 8];
    end else if (st == CIE_ST_RETURN && cnt < 4'(CIE_PC_BYTES)) begin
      stack_re_o = 1'b1;
      stack_addr_o = sp + 16'(cnt) + 16'd1;
    end
    if (entry_end) begin
      pc_load_addr_o = vec_addr(vsel, sel);
    end
  end

  // stack pointer: down by three on entry, up by three on return
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sp <= CIE_SP_RST;
    end else if (entry_end) begin
      sp <= sp - 16'(CIE_PC_BYTES);
    end else if (ret_end) begin
      sp <= sp + 16'(CIE_PC_BYTES);
    end else if (apb_wr && paddr_i == CIE_OFF_SP) begin
      sp <= pwdata_i[15:0];
    end
  end

  // global enable: entry and clear win over software set paths
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gie <= CIE_GIE_RST;
    end else if (take) begin
      gie <= 1'b0;
    end else if (ret_end) begin
      gie <= 1'b1;
    end else if (clr_gie_instr_i) begin
      gie <= 1'b0;
    end else if (set_gie_instr_i) begin
      gie <= 1'b1;
    end else if (apb_wr && paddr_i == CIE_OFF_CTRL) begin
      gie <= pwdata_i[CIE_CTRL_GIE_BIT];
    end
  end

  // pending flags: a new event beats any clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flags <= '0;
    end else begin
      flags <= ((flags & ~w1c & ~src_ack_o) | src_event_i) & ~LEVEL_MASK;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      enable <= '0;
      vsel <= CIE_VSEL_RST;
    end else if (apb_wr && paddr_i == CIE_OFF_ENABLE) begin
      enable <= pwdata_i[NSRC-1:0];
    end else if (apb_wr && paddr_i == CIE_OFF_CTRL) begin
      vsel <= pwdata_i[CIE_CTRL_VSEL_BIT];
    end
  end

  // strap sampled by the clock, not by the reset itself
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reset_vector_o <= '0;
    end else begin
      reset_vector_o <= boot_reset_fuse_i ? BOOT_START : '0;
    end
  end

  // read data latched in the setup phase so it is a flop in the access phase
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        CIE_OFF_CTRL: prdata_o <= 32'({vsel, gie});
        CIE_OFF_FLAG: prdata_o <= 32'(pending);
        CIE_OFF_ENABLE: prdata_o <= 32'(enable);
        CIE_OFF_SP: prdata_o <= 32'(sp);
        CIE_OFF_STATE: prdata_o <= {8'h00, 4'(sel), cnt, 14'h0000, st};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // one-cycle alu: operands read and result written at the same edge, no divided clock
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      alu_result_o <= 8'h00;
      // the file has no load port, so each entry starts at its own index
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= 8'(i);
      end
    end else if (alu_valid_i) begin
      case (cie_alu_t'(alu_op_i))
        CIE_ALU_ADD: begin
          regs[alu_rd_i] <= regs[alu_rd_i] + regs[alu_rr_i];
          alu_result_o <= regs[alu_rd_i] + regs[alu_rr_i];
        end
        CIE_ALU_SUB: begin
          regs[alu_rd_i] <= regs[alu_rd_i] - regs[alu_rr_i];
          alu_result_o <= regs[alu_rd_i] - regs[alu_rr_i];
        end
        CIE_ALU_AND: begin
          regs[alu_rd_i] <= regs[alu_rd_i] & regs[alu_rr_i];
          alu_result_o <= regs[alu_rd_i] & regs[alu_rr_i];
        end
        default: begin
          regs[alu_rd_i] <= regs[alu_rd_i] | regs[alu_rr_i];
          alu_result_o <= regs[alu_rd_i] | regs[alu_rr_i];
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_entry_five_cycles: assert property (
    (take && !sleep_i) |-> !pc_load_o [*5] ##1 pc_load_o)
    else $error("entry did not take five cycles");
  a_wake_extra: assert property (
    (take && sleep_i) |-> !pc_load_o [*8] ##1 !pc_load_o [*2] ##1 pc_load_o)
    else $error("wake entry not ten cycles");
  a_return_five: assert property (
    ret_start |-> ##5 pc_load_o ##1 (gie && sp == $past(sp, 6) + 16'(CIE_PC_BYTES)))
    else $error("return timing or pop wrong");
  a_entry_clears_gie: assert property (
    take |=> !gie)
    else $error("global enable kept on entry");
  a_enable_gate: assert property (
    take |-> (gie && (src_ack_o & ~enable) == '0))
    else $error("disabled source taken");
  a_priority_pick: assert property (
    take |-> ($onehot(src_ack_o) && (src_ack_o & req) != '0 &&
              (req & (src_ack_o - NSRC'(1))) == '0))
    else $error("lower priority taken first");
  a_clear_blocks: assert property (
    clr_gie_instr_i |-> !take)
    else $error("taken despite clear-enable");
  a_sp_push: assert property (
    (take && !sleep_i) |-> ##6 sp == $past(sp, 6) - 16'(CIE_PC_BYTES))
    else $error("stack pointer push wrong");
  a_flag_hw_clear: assert property (
    (take && src_event_i == '0) |=> (flags & sel_onehot) == '0)
    else $error("flag not cleared on vectoring");
  a_vector_addr: assert property (
    entry_end |-> pc_load_addr_o == (vsel ? BOOT_START : PC_W'(0)) +
                  PC_W'((32'(sel) + 32'd1) * 32'(CIE_VEC_WORDS)))
    else $error("vector address wrong");

  c_take: cover property (take);
  c_return: cover property (ret_end);
  c_wake: cover property (take && sleep_i);
  c_nested: cover property (st == CIE_ST_ENTRY ##[1:200] take);

endmodule : cie_unit
`default_nettype wire

/* src/cie_pkg.sv */
// cie_pkg: constants shared by the interrupt entry and return unit
package cie_pkg;
  // register byte offsets
  localparam logic [7:0] CIE_OFF_CTRL = 8'h00;
  localparam logic [7:0] CIE_OFF_FLAG = 8'h04;
  localparam logic [7:0] CIE_OFF_ENABLE = 8'h08;
  localparam logic [7:0] CIE_OFF_SP = 8'h0C;
  localparam logic [7:0] CIE_OFF_STATE = 8'h10;
  // core_control_register fields
  localparam int CIE_CTRL_GIE_BIT = 0;
  localparam int CIE_CTRL_VSEL_BIT = 1;
  // reset values
  localparam logic CIE_GIE_RST = 1'b0;
  localparam logic CIE_VSEL_RST = 1'b0;
  localparam logic [15:0] CIE_SP_RST = 16'h21FF;
  // timing in core_clock cycles
  localparam int CIE_ENTRY_CYCLES = 5;
  localparam int CIE_WAKE_EXTRA_CYCLES = 5;
  localparam int CIE_RETURN_CYCLES = 5;
  localparam int CIE_PC_BYTES = 3;
  // program words per vector slot
  localparam int CIE_VEC_WORDS = 2;
  typedef enum logic [1:0] {
    CIE_ST_IDLE = 2'b00,
    CIE_ST_ENTRY = 2'b01,
    CIE_ST_RETURN = 2'b10
  } cie_state_t;
  typedef enum logic [1:0] {
    CIE_ALU_ADD = 2'b00,
    CIE_ALU_SUB = 2'b01,
    CIE_ALU_AND = 2'b10,
    CIE_ALU_OR = 2'b11
  } cie_alu_t;
endpackage : cie_pkg

/* testbench/cie_stack_model.sv */
// cie_stack_model: byte-wide stack memory behind the unit, read data one cycle late
`timescale 1ns/1ps
`default_nettype none
module cie_stack_model (
  input wire logic core_clk_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  initial rdata_o = 8'h00;
  // outside a read the data line flips, so a late capture cannot pass by luck
  always @(posedge core_clk_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    if (re_i) rdata_o <= mem[addr_i];
    else rdata_o <= ~rdata_o;
  end
endmodule : cie_stack_model
`default_nettype wire

/* testbench/test_cpu_interrupt_entry_return.sv */
// test_cpu_interrupt_entry_return: self-checking bench for the interrupt entry and return unit
`timescale 1ns/1ps
`default_nettype none
module test_cpu_interrupt_entry_return import cie_pkg::*;;
  localparam logic [16:0] BOOT = 17'h1E000;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic idone = 1'b0, setg = 1'b0, clrg = 1'b0, return_from_handler_instr = 1'b0, slp = 1'b0, wrdy = 1'b0;
  logic fuse = 1'b1, lka = 1'b0, lkb = 1'b0;
  logic av = 1'b0, apend = 1'b0;
  logic [1:0] aop = 2'h0;
  logic [4:0] ard = 5'h00, arr = 5'h00;
  logic [7:0] ares;
  logic [7:0] am [32];
  logic [16:0] pcor = 17'h00000;
  logic [31:0] q_alu [$];
  logic pready, pslverr, busy, pcl, gie, swe, sre, e;
  logic [7:0] paddr = 8'h00, sev = 8'h00, slv = 8'h00, ack, swd, srd;
  logic [15:0] sadr;
  logic [16:0] pc = 17'h00000, lpc, pcla, rvec;
  logic [31:0] pwdata = 32'h00000000, prdata, r, ev;
  logic [31:0] seed = 32'hAC938884;
  logic [31:0] q_ack [$];
  logic [31:0] q_pc [$];
  int err_count = 0, num_checks = 0;
  always #5 clk = ~clk;
  cie_unit #(.BOOT_START(BOOT), .LEVEL_MASK(8'h80)) i_dut (.core_clk_i(clk), .rst_i(rst),
    .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .src_event_i(sev), .src_level_i(slv),
    .src_ack_o(ack), .boot_reset_fuse_i(fuse), .boot_lock_app_bit_i(lka),
    .boot_lock_boot_bit_i(lkb), .pc_i(pc), .instr_done_i(idone), .set_gie_instr_i(setg),
    .clr_gie_instr_i(clrg), .return_from_handler_instr_i(return_from_handler_instr), .sleep_i(slp),
    .wake_ready_i(wrdy), .busy_o(busy), .pc_load_o(pcl), .pc_load_addr_o(pcla),
    .reset_vector_o(rvec), .global_enable_o(gie), .stack_we_o(swe), .stack_re_o(sre),
    .stack_addr_o(sadr), .stack_wdata_o(swd), .stack_rdata_i(srd), .alu_valid_i(av),
    .alu_op_i(aop), .alu_rd_i(ard), .alu_rr_i(arr), .alu_result_o(ares));
  cie_stack_model i_stack (.core_clk_i(clk), .we_i(swe), .re_i(sre), .addr_i(sadr),
    .wdata_i(swd), .rdata_o(srd));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // setup then access; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h00000000);
    chk(nm, r, exp);
  endtask : rd
  task automatic pulse(input logic s, input logic c, input logic q);
    logic [31:0] t;
    t = rnd();
    lpc = t[16:0] | pcor;
    pc <= lpc; idone <= 1'b1; setg <= s; clrg <= c; return_from_handler_instr <= q;
    @(posedge clk);
    idone <= 1'b0; setg <= 1'b0; clrg <= 1'b0; return_from_handler_instr <= 1'b0;
    @(posedge clk);
  endtask : pulse
  task automatic wait_pl();
    int n;
    n = 0;
    while (q_pc.size() != 0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("pc load wait", q_pc.size(), 0);
    @(posedge clk);
  endtask : wait_pl
  task automatic enter(input int k, input logic [16:0] base);
    q_ack.push_back(32'h1 << k);
    q_pc.push_back({15'h0000, base + 17'(2 * (k + 1))});
    pulse(1'b0, 1'b0, 1'b0);
    wait_pl();
  endtask : enter
  task automatic leave();
    q_pc.push_back({15'h0000, lpc});
    pulse(1'b0, 1'b0, 1'b1);
    wait_pl();
  endtask : leave
  // one register-file operation per cycle; the caller lowers the strobe after the last one
  task automatic alu(input logic [31:0] t);
    logic [7:0] x;
    case (t[1:0])
      2'h0: x = am[t[6:2]] + am[t[11:7]];
      2'h1: x = am[t[6:2]] - am[t[11:7]];
      2'h2: x = am[t[6:2]] & am[t[11:7]];
      default: x = am[t[6:2]] | am[t[11:7]];
    endcase
    am[t[6:2]] = x;
    q_alu.push_back({24'h000000, x});
    av <= 1'b1;
    aop <= t[1:0];
    ard <= t[6:2];
    arr <= t[11:7];
    @(posedge clk);
  endtask : alu
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // monitor: every acknowledge and program counter load must match the oldest note
  always @(posedge clk) begin
    if (!rst && ack !== 8'h00) begin
      if (q_ack.size() == 0) chk("unexpected ack", {24'h0, ack}, 0);
      else chk("ack", {24'h0, ack}, q_ack.pop_front());
    end
    if (!rst && pcl === 1'b1) begin
      if (q_pc.size() == 0) chk("unexpected pc load", {15'h0, pcla}, 0);
      else chk("pc load addr", {15'h0, pcla}, q_pc.pop_front());
    end
    if (apend) chk("alu result", {24'h0, ares}, q_alu.pop_front());
    apend = av;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 32; i++) begin
      am[i] = 8'(i);
    end
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset vector", {15'h0, rvec}, {15'h0, BOOT});
    rd(CIE_OFF_CTRL, 32'h00000000, "ctrl");
    rd(CIE_OFF_SP, 32'h000021FF, "sp");
    apb(1'b0, 8'h14, 32'h00000000);
    chk("unmapped err", {31'h0, e}, 1);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      alu(rnd());
    end
    av <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    $display("test alu done");
    apb(1'b1, CIE_OFF_ENABLE, 32'h00000005);
    sev <= 8'h0D;
    @(posedge clk);
    sev <= 8'h00;
    @(posedge clk);
    rd(CIE_OFF_FLAG, 32'h0000000D, "flags held");
    pulse(1'b0, 1'b0, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    chk("gie after set", {31'h0, gie}, 1);
    enter(0, 17'h00000);
    chk("gie after entry", {31'h0, gie}, 0);
    rd(CIE_OFF_SP, 32'h000021FC, "sp pushed");
    rd(CIE_OFF_FLAG, 32'h0000000C, "flag cleared");
    leave();
    chk("gie after return", {31'h0, gie}, 1);
    rd(CIE_OFF_SP, 32'h000021FF, "sp popped");
    pulse(1'b0, 1'b1, 1'b0);
    chk("gie after clear", {31'h0, gie}, 0);
    $display("test entry and return done");
    apb(1'b1, CIE_OFF_CTRL, 32'h00000003);
    enter(2, BOOT);
    leave();
    apb(1'b1, CIE_OFF_FLAG, 32'h00000000);
    rd(CIE_OFF_FLAG, 32'h00000008, "flag kept");
    apb(1'b1, CIE_OFF_FLAG, 32'h00000008);
    rd(CIE_OFF_FLAG, 32'h00000000, "flag w1c");
    $display("test relocation and flag clear done");
    apb(1'b1, CIE_OFF_ENABLE, 32'h000000FF);
    apb(1'b1, CIE_OFF_CTRL, 32'h00000001);
    for (int i = 0; i < 4; i++) begin
      // bit 7 is the level source and keeps no flag
      ev = (rnd() | 32'h00000010) & 32'h0000007F;
      sev <= ev[7:0];
      @(posedge clk);
      sev <= 8'h00;
      @(posedge clk);
      for (int k = 0; k < 8; k++) begin
        if (ev[k]) begin
          enter(k, 17'h00000);
          leave();
        end
      end
    end
    rd(CIE_OFF_FLAG, 32'h00000000, "all served");
    $display("test random priority done");
    apb(1'b1, CIE_OFF_ENABLE, 32'h00000003);
    sev <= 8'h02;
    @(posedge clk);
    sev <= 8'h00;
    enter(1, 17'h00000);
    ev = {15'h0000, lpc};
    apb(1'b1, CIE_OFF_CTRL, 32'h00000001);
    sev <= 8'h01;
    @(posedge clk);
    sev <= 8'h00;
    enter(0, 17'h00000);
    rd(CIE_OFF_SP, 32'h000021F9, "sp nested");
    leave();
    q_pc.push_back(ev);
    pulse(1'b0, 1'b0, 1'b1);
    wait_pl();
    rd(CIE_OFF_SP, 32'h000021FF, "sp unwound");
    $display("test nesting done");
    apb(1'b1, CIE_OFF_ENABLE, 32'h000000FF);
    sev <= 8'h04;
    @(posedge clk);
    sev <= 8'h00;
    q_ack.push_back(32'h00000004);
    q_pc.push_back(32'h00000006);
    slp <= 1'b1;
    wrdy <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    wrdy <= 1'b0;
    wait_pl();
    leave();
    $display("test wake done");
    lkb <= 1'b1;
    pcor = BOOT;
    sev <= 8'h01;
    @(posedge clk);
    sev <= 8'h00;
    pulse(1'b0, 1'b0, 1'b0);
    chk("gie kept while locked", {31'h0, gie}, 1);
    lkb <= 1'b0;
    enter(0, 17'h00000);
    leave();
    pcor = 17'h00000;
    $display("test boot lock done");
    apb(1'b1, CIE_OFF_CTRL, 32'h00000000);
    slv <= 8'h80;
    rd(CIE_OFF_FLAG, 32'h00000080, "level live");
    slv <= 8'h00;
    apb(1'b1, CIE_OFF_CTRL, 32'h00000001);
    pulse(1'b0, 1'b0, 1'b0);
    slv <= 8'h80;
    enter(7, 17'h00000);
    slv <= 8'h00;
    leave();
    rd(CIE_OFF_FLAG, 32'h00000000, "level gone");
    $display("test level source done");
    end_of_test();
  end
endmodule : test_cpu_interrupt_entry_return
`default_nettype wire
